// >>> rcmd_defs.svh
// Named constants for the reference clock monitor and divider block.
// Assumes inclusion by bare name before the package and the top module.
`ifndef RCMD_DEFS_SVH
`define RCMD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define RCMD_IDX_REF_DIV     3'h0
`define RCMD_IDX_FB_HI       3'h1
`define RCMD_IDX_FB_LO       3'h2
`define RCMD_IDX_OUT_A       3'h3
`define RCMD_IDX_OUT_B       3'h4
`define RCMD_IDX_CTRL5       3'h5
`define RCMD_IDX_CTRL6       3'h6
`define RCMD_IDX_STATUS      3'h7
`define RCMD_ADR_HI_ZERO     3'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RCMD_C5_FORCE_LOW    7
`define RCMD_C5_OE_A         6
`define RCMD_C5_OE_B         5
`define RCMD_C5_DEFAULT      4
`define RCMD_C5_DIS_HI       3
`define RCMD_C5_DIS_LO       2
`define RCMD_C5_REVERT       1
`define RCMD_C5_MON_RST      0
`define RCMD_C6_DEV_RST      4
`define RCMD_C6_SWAP         3
`define RCMD_C6_B_SRC        2
`define RCMD_ST_FAIL_A       6
`define RCMD_ST_FAIL_B       5
`define RCMD_ST_SEL          4
`define RCMD_OUT_CODE_HI     2

// ----------------------------------------------------------------------------
// Pin vector positions and reset values
// ----------------------------------------------------------------------------
`define RCMD_PIN_REF_A       0
`define RCMD_PIN_REF_B       1
`define RCMD_PIN_SEL_A       2
`define RCMD_PIN_SEL_B       3
`define RCMD_PIN_MON_N       4
`define RCMD_PIN_MR          5
`define RCMD_PIN_LVL_RST     6'h1C
`define RCMD_CR_RST          8'h00
`define RCMD_CR5_RST         8'h60
`define RCMD_DIS_PINS        2'h0
`define RCMD_DIS_BOTH        2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RCMD_FAIL_CYCLES     2
`define RCMD_ALIGN_CYCLES    9'd480

`endif

// >>> rcmd_pkg.sv
// Types shared by the reference clock monitor and divider block.
// Assumes rcmd_defs.svh is compiled alongside.
package rcmd_pkg;

   // Output divider state, one-hot.
   typedef enum logic [1:0] {
      RCMD_DIV_RUN  = 2'b01,
      RCMD_DIV_HOLD = 2'b10
   } rcmd_div_state_e;

   typedef logic [7:0] rcmd_byte_t;

endpackage

// >>> rcmd_top.sv
// Reference clock monitor, input selection and output dividers with a
// classic Wishbone register slave.
// Assumes core_clk is the oscillator clock; all pins are asynchronous.
//
// Behaviour
// - Eight 8-bit host-accessible registers.
// - Fixed register roles: dividers, control, status.
// - Divided outputs share coincident rising edges.
// - Ratio change: finish period, low, new edge.
// - Force-low bit drives all outputs low.
// - Per-output enables; disabled output floats.
// - Second output source chosen by control bit.
// - Default bit and swap bit pick input.
// - Inputs disabled by pins or control bits.
// - Output frequency is core clock over twice the output factor.
// - Feedback factor spans 1 to 32768.
// - Output factors 1,2,3,4,5,6,8,16 only.
// - Reference factor spans 1 to 256.
// - Both inputs monitored at once.
// - Two quiet cycles flag input failure.
// - Failure switches input and loads status.
// - Monitor idle while control disables inputs.
// - Revert: recovery clears flags, reselects default.
// - No revert: failure flags stick until reset.
// - Control bit enables revert behaviour.
// - Four rising sources clear monitor faults.
// - Monitor reset clears flags, selects default.
// - Disable field codes override select pins.
// - Device reset restores all registers.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`include "rcmd_defs.svh"

module rcmd_top
   import rcmd_pkg::*;
#(
   parameter int FAIL_CYCLES = `RCMD_FAIL_CYCLES
) (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Reference inputs and control pins.
   input  wire logic        reference_input_a,
   input  wire logic        reference_input_b,
   input  wire logic        input_a_select_pin,
   input  wire logic        input_b_select_pin,
   input  wire logic        monitor_enable_n_pin,
   input  wire logic        master_reset_pin,
   // Clock outputs and failure indicator.
   output logic             clock_output_a,
   output logic             clock_output_a_oe,
   output logic             clock_output_b,
   output logic             clock_output_b_oe,
   output logic             failure_flag
);

   localparam int QW = $clog2(FAIL_CYCLES + 1);

   // ------------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------------
   logic [5:0] pin_raw;
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic [5:0] pin_s3_q;
   logic [5:0] pin_lvl_q;
   logic [5:0] pin_lvl_d;
   logic [5:0] pin_agree;
   logic [5:0] pin_rise;

   assign pin_raw = {master_reset_pin, monitor_enable_n_pin, input_b_select_pin,
                     input_a_select_pin, reference_input_b, reference_input_a};
   // A change is accepted only once the second and third stages agree.
   assign pin_agree = ~(pin_s2_q ^ pin_s3_q);
   assign pin_lvl_d = (pin_agree & pin_s2_q) | (~pin_agree & pin_lvl_q);
   assign pin_rise  = pin_lvl_d & ~pin_lvl_q;

   // Three-stage capture of every asynchronous pin.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q  <= `RCMD_PIN_LVL_RST;
         pin_s2_q  <= `RCMD_PIN_LVL_RST;
         pin_s3_q  <= `RCMD_PIN_LVL_RST;
         pin_lvl_q <= `RCMD_PIN_LVL_RST;
      end else begin
         pin_s1_q  <= pin_raw;
         pin_s2_q  <= pin_s1_q;
         pin_s3_q  <= pin_s2_q;
         pin_lvl_q <= pin_lvl_d;
      end
   end

   // ------------------------------------------------------------------------
   // Register file and bus decode
   // ------------------------------------------------------------------------
   rcmd_byte_t cr_q [7];
   rcmd_byte_t status;
   rcmd_byte_t rd_byte;
   logic       ack_q;
   logic [31:0] dat_q;
   logic       bus_req;
   logic       mapped;
   logic [2:0] idx;
   logic       wr_en;
   logic       wr_c5;
   logic       wr_c6;
   logic       c5_mon_rise;
   logic       c6_rst_rise;
   logic       dev_rst;
   logic       mon_rst;

   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign idx     = wb_adr_i[4:2];
   assign mapped  = (wb_adr_i[7:5] == `RCMD_ADR_HI_ZERO);
   // Only the low byte lane carries data; other lanes alone do not write.
   assign wr_en   = bus_req & wb_we_i & wb_sel_i[0] & mapped;
   assign wr_c5   = wr_en & (idx == `RCMD_IDX_CTRL5);
   assign wr_c6   = wr_en & (idx == `RCMD_IDX_CTRL6);
   assign c5_mon_rise = wr_c5 & wb_dat_i[`RCMD_C5_MON_RST]
                        & ~cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_MON_RST];
   assign c6_rst_rise = wr_c6 & wb_dat_i[`RCMD_C6_DEV_RST]
                        & ~cr_q[`RCMD_IDX_CTRL6][`RCMD_C6_DEV_RST];
   // The pin reset acts as a level; the register bit acts on its rising write.
   assign dev_rst = pin_lvl_q[`RCMD_PIN_MR] | c6_rst_rise;
   assign mon_rst = pin_rise[`RCMD_PIN_MON_N] | pin_rise[`RCMD_PIN_MR]
                    | c5_mon_rise | c6_rst_rise;
   assign rd_byte = (idx == `RCMD_IDX_STATUS) ? status : cr_q[idx];

   // Writable registers; a device reset returns every one to its default.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 7; i++) begin
            cr_q[i] <= (i == 5) ? `RCMD_CR5_RST : `RCMD_CR_RST;
         end
      end else if (dev_rst) begin
         for (int i = 0; i < 7; i++) begin
            cr_q[i] <= (i == 5) ? `RCMD_CR5_RST : `RCMD_CR_RST;
         end
      end else if (wr_en && idx != `RCMD_IDX_STATUS) begin
         cr_q[idx] <= wb_dat_i[7:0];
      end
   end

   // One wait state: ack and read data both rise the cycle after the request.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         dat_q <= (bus_req && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ------------------------------------------------------------------------
   // Input enables and monitor
   // ------------------------------------------------------------------------
   logic [1:0]  dis;
   logic [1:0]  in_en;
   logic        revert;
   logic        mon_active;
   logic        default_sel;
   logic [1:0]  trans;
   logic [1:0]  dead;
   logic [1:0]  fail_set;
   logic [1:0]  recover;
   logic [1:0]  fail_q;
   logic [1:0]  fail_d;
   logic [1:0]  usable;
   logic        sel_q;
   logic        sel_d;
   logic        int_q;
   logic [QW-1:0] quiet_q [2];

   assign dis    = cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_DIS_HI:`RCMD_C5_DIS_LO];
   // Code zero hands control to the pins, otherwise each bit enables one input.
   assign in_en  = (dis == `RCMD_DIS_PINS) ?
                   {pin_lvl_q[`RCMD_PIN_SEL_B], pin_lvl_q[`RCMD_PIN_SEL_A]} : dis;
   assign revert = cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_REVERT];
   // Codes that switch one input off by register idle the monitor; both-on keeps it.
   assign mon_active = ((dis == `RCMD_DIS_PINS) | (dis == `RCMD_DIS_BOTH))
                       & ~pin_lvl_q[`RCMD_PIN_MON_N];
   assign default_sel = cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_DEFAULT];
   assign trans  = pin_s2_q[1:0] ^ pin_s3_q[1:0];
   assign usable = in_en & ~fail_q & ~dead;

   // Quiet-cycle counters run on both inputs regardless of selection.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_mon
         assign dead[gi]     = (quiet_q[gi] >= QW'(FAIL_CYCLES));
         assign fail_set[gi] = mon_active & in_en[gi] & dead[gi];
         assign recover[gi]  = fail_q[gi] & trans[gi] & revert;
         // A new failure wins over any clear arriving in the same cycle.
         assign fail_d[gi]   = fail_set[gi] ? 1'b1 :
                               (mon_rst | dev_rst | recover[gi]) ? 1'b0 :
                               fail_q[gi];
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               quiet_q[gi] <= '0;
            end else if (trans[gi]) begin
               quiet_q[gi] <= '0;
            end else if (!dead[gi]) begin
               quiet_q[gi] <= quiet_q[gi] + QW'(1);
            end
         end
      end
   endgenerate

   // Selection priority: device reset, failover, monitor reset, revert, write.
   always_comb begin
      sel_d = sel_q;
      if (dev_rst) begin
         sel_d = 1'b0;
      end else if (fail_set[sel_q] && usable[~sel_q]) begin
         sel_d = ~sel_q;
      end else if (mon_rst) begin
         sel_d = default_sel;
      end else if (recover[default_sel] && !fail_set[default_sel]) begin
         sel_d = default_sel;
      end else if (wr_c5 || wr_c6) begin
         sel_d = (wr_c5 ? wb_dat_i[`RCMD_C5_DEFAULT] : default_sel)
                 ^ (wr_c6 ? wb_dat_i[`RCMD_C6_SWAP]
                          : cr_q[`RCMD_IDX_CTRL6][`RCMD_C6_SWAP]);
      end
   end

   // Monitor state; the indicator is a flop copy of any failure.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fail_q <= 2'b00;
         sel_q  <= 1'b0;
         int_q  <= 1'b0;
      end else begin
         fail_q <= fail_d;
         sel_q  <= sel_d;
         int_q  <= |fail_d;
      end
   end
   assign failure_flag = int_q;

   // Status reflects live monitor state, so it is reloaded on every event.
   always_comb begin
      status = 8'h00;
      status[`RCMD_ST_FAIL_A] = fail_q[0];
      status[`RCMD_ST_FAIL_B] = fail_q[1];
      status[`RCMD_ST_SEL]    = sel_q;
   end

   // ------------------------------------------------------------------------
   // Output dividers
   // ------------------------------------------------------------------------
   // Each output period is twice the ratio in core cycles, so a flop can
   // produce ratio one; the loop factors are held for the analog loop.
   logic [8:0]  align_q;
   logic        align_end;
   logic [2:0]  code [2];
   logic [1:0]  div_out_q;
   logic        out_a_q;
   logic        out_b_q;
   logic        oe_a_q;
   logic        oe_b_q;
   rcmd_div_state_e div_st_q [2];
   logic [15:0] fb_factor;
   logic [8:0]  ref_factor;

   // Stored code plus one gives the loop factors; read only by the loop.
   assign fb_factor  = {cr_q[`RCMD_IDX_FB_HI][6:0], cr_q[`RCMD_IDX_FB_LO]} + 16'h0001;
   assign ref_factor = {1'b0, cr_q[`RCMD_IDX_REF_DIV]} + 9'h001;
   assign code[0]    = cr_q[`RCMD_IDX_OUT_A][`RCMD_OUT_CODE_HI:0];
   assign code[1]    = cr_q[`RCMD_IDX_OUT_B][`RCMD_OUT_CODE_HI:0];
   assign align_end  = (align_q == `RCMD_ALIGN_CYCLES - 9'd1);

   // Only eight ratios exist; the three-bit code indexes them.
   function automatic logic [4:0] ratio_of(input logic [2:0] c);
      unique case (c)
         3'h0: ratio_of = 5'h01;
         3'h1: ratio_of = 5'h02;
         3'h2: ratio_of = 5'h03;
         3'h3: ratio_of = 5'h04;
         3'h4: ratio_of = 5'h05;
         3'h5: ratio_of = 5'h06;
         3'h6: ratio_of = 5'h08;
         3'h7: ratio_of = 5'h10;
      endcase
   endfunction

   // Shared phase counter over the common multiple of all periods.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         align_q <= 9'h000;
      end else begin
         align_q <= align_end ? 9'h000 : align_q + 9'h001;
      end
   end

   generate
      for (gi = 0; gi < 2; gi++) begin : g_div
         logic [4:0] cnt_q;
         logic [2:0] cur_q;
         logic [4:0] n_cur;
         logic       per_end;
         assign n_cur   = ratio_of(cur_q);
         assign per_end = (cnt_q == {n_cur[3:0], 1'b0} - 5'h01);
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_q         <= 5'h00;
               cur_q         <= 3'h0;
               div_st_q[gi]  <= RCMD_DIV_RUN;
               div_out_q[gi] <= 1'b1;
            end else begin
               unique case (div_st_q[gi])
                  RCMD_DIV_RUN: begin
                     if (per_end && code[gi] != cur_q) begin
                        div_st_q[gi]  <= RCMD_DIV_HOLD;
                        div_out_q[gi] <= 1'b0;
                     end else begin
                        cnt_q         <= per_end ? 5'h00 : cnt_q + 5'h01;
                        div_out_q[gi] <= per_end | (cnt_q + 5'h01 < n_cur);
                     end
                  end
                  RCMD_DIV_HOLD: begin
                     // Restart only on the shared phase so edges coincide.
                     if (align_end) begin
                        div_st_q[gi]  <= RCMD_DIV_RUN;
                        cur_q         <= code[gi];
                        cnt_q         <= 5'h00;
                        div_out_q[gi] <= 1'b1;
                     end
                  end
               endcase
            end
         end
      end
   endgenerate

   // Output stage: force-low, enables and second-output source.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
         oe_a_q  <= 1'b0;
         oe_b_q  <= 1'b0;
      end else begin
         oe_a_q  <= cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_OE_A];
         oe_b_q  <= cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_OE_B];
         out_a_q <= div_out_q[0] & cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_OE_A]
                    & ~cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_FORCE_LOW];
         out_b_q <= (cr_q[`RCMD_IDX_CTRL6][`RCMD_C6_B_SRC] ? div_out_q[1] : div_out_q[0])
                    & cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_OE_B]
                    & ~cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_FORCE_LOW];
      end
   end
   assign clock_output_a    = out_a_q;
   assign clock_output_b    = out_b_q;
   assign clock_output_a_oe = oe_a_q;
   assign clock_output_b_oe = oe_b_q;

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   property p_force_low;
      @(posedge core_clk) disable iff (!rst_b)
      cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_FORCE_LOW] |=> !clock_output_a && !clock_output_b;
   endproperty
   a_force_low: assert property (p_force_low) else $error("output not forced low");

   property p_oe_off;
      @(posedge core_clk) disable iff (!rst_b)
      !cr_q[`RCMD_IDX_CTRL5][`RCMD_C5_OE_A] |=> !clock_output_a_oe && !clock_output_a;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("disabled output still driven");

   property p_b_source;
      @(posedge core_clk) disable iff (!rst_b)
      (cr_q[`RCMD_IDX_CTRL6][`RCMD_C6_B_SRC] && cr_q[`RCMD_IDX_CTRL5] == `RCMD_CR5_RST)
      |=> clock_output_b == $past(div_out_q[1]);
   endproperty
   a_b_source: assert property (p_b_source) else $error("wrong source on output b");

   property p_align;
      @(posedge core_clk) disable iff (!rst_b)
      (align_q == 9'h000 && div_st_q[0] == RCMD_DIV_RUN && div_st_q[1] == RCMD_DIV_RUN)
      |-> div_out_q == 2'b11;
   endproperty
   a_align: assert property (p_align) else $error("divider edges not aligned");

   property p_hold_low;
      @(posedge core_clk) disable iff (!rst_b)
      (div_st_q[0] == RCMD_DIV_HOLD) |-> !div_out_q[0];
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("runt during ratio change");

   property p_fail_flag;
      @(posedge core_clk) disable iff (!rst_b)
      fail_set[0] |=> status[`RCMD_ST_FAIL_A] && failure_flag;
   endproperty
   a_fail_flag: assert property (p_fail_flag) else $error("failure not reported");

   property p_failover;
      @(posedge core_clk) disable iff (!rst_b)
      (fail_set[sel_q] && usable[~sel_q] && !dev_rst) |=> sel_q != $past(sel_q);
   endproperty
   a_failover: assert property (p_failover) else $error("no switch after failure");

   property p_sticky;
      @(posedge core_clk) disable iff (!rst_b)
      (fail_q[1] && !revert && !mon_rst && !dev_rst) |=> fail_q[1] && failure_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("failure cleared without reset");

   property p_mon_idle;
      @(posedge core_clk) disable iff (!rst_b)
      (dis != `RCMD_DIS_PINS && dis != `RCMD_DIS_BOTH) |-> fail_set == 2'b00;
   endproperty
   a_mon_idle: assert property (p_mon_idle) else $error("monitor active while disabled");

   property p_mon_reset;
      @(posedge core_clk) disable iff (!rst_b)
      (mon_rst && fail_set == 2'b00) |=> fail_q == 2'b00 && !failure_flag;
   endproperty
   a_mon_reset: assert property (p_mon_reset) else $error("monitor reset did not clear");

   property p_ack;
      @(posedge core_clk) disable iff (!rst_b)
      bus_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer timing wrong");

   c_failover: cover property (@(posedge core_clk) disable iff (!rst_b)
                               fail_set[sel_q] && usable[~sel_q]);
   c_revert:   cover property (@(posedge core_clk) disable iff (!rst_b) recover[0]);
   c_ratio:    cover property (@(posedge core_clk) disable iff (!rst_b)
                               div_st_q[1] == RCMD_DIV_HOLD ##1 div_st_q[1] == RCMD_DIV_RUN);

endmodule

// >>> rcmd_ref_model.sv
// Two reference clock sources for the monitor bench.
// Assumes the bench gates each source with a run level.
`timescale 1ns/10ps
module rcmd_ref_model #(
   parameter real HALF_A = 30.0,
   parameter real HALF_B = 33.0
) (
   // Run controls.
   input  wire logic run_a,
   input  wire logic run_b,
   // Reference clocks.
   output logic      reference_input_a,
   output logic      reference_input_b
);
   // A stopped source parks low, as a dead oscillator would.
   initial begin
      reference_input_a = 1'b0;
      reference_input_b = 1'b0;
   end
   always #(HALF_A) reference_input_a = run_a ? ~reference_input_a : 1'b0;
   always #(HALF_B) reference_input_b = run_b ? ~reference_input_b : 1'b0;
endmodule

// >>> reference_clock_monitor_divider_tb.sv
// Self-checking bench for the clock monitor and divider block.
// Assumes the design files and the source model are compiled first.
`timescale 1ns/10ps
module reference_clock_monitor_divider_tb
   import rcmd_pkg::*;
;
   logic        core_clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, sel_a, sel_b, mon_n, mr;
   logic        run_a, run_b, ref_a, ref_b, out_a, oe_a, out_b, oe_b, fail, seen;
   logic [3:0]  wb_sel;
   logic [7:0]  wb_adr;
   logic [31:0] wb_dat, wb_rdat, rd;
   int          bad_count, samples_checked, n;
   logic [23:0] rows [7] = '{24'h00FFFF, 24'h047F7F, 24'h08A5A5, 24'h0C0707,
                            24'h100505, 24'h1CFF00, 24'h205500};

   always #25 core_clk = ~core_clk;

   // Quiet threshold raised so the unrelated reference phases never look dead.
   rcmd_top #(.FAIL_CYCLES(4)) DUT (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .reference_input_a(ref_a),
      .reference_input_b(ref_b), .input_a_select_pin(sel_a), .input_b_select_pin(sel_b),
      .monitor_enable_n_pin(mon_n), .master_reset_pin(mr), .clock_output_a(out_a),
      .clock_output_a_oe(oe_a), .clock_output_b(out_b), .clock_output_b_oe(oe_b),
      .failure_flag(fail));
   rcmd_ref_model SRC (.run_a(run_a), .run_b(run_b), .reference_input_a(ref_a),
      .reference_input_b(ref_b));

   task automatic complete_run;
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_sel <= 4'h1;
      wb_adr <= a;
      wb_dat <= {24'h0, d};
      do begin
         @(posedge core_clk);
         k++;
      end while (wb_ack !== 1'b1 && k < 20);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (k >= 20) begin
         bad_count++;
         complete_run();
      end
   endtask

   // Waits for the failure flag (0) or output A high (1).
   task automatic await(input int which, input int lim);
      int k;
      k = 0;
      while ((which ? out_a : fail) !== 1'b1 && k < lim) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= lim) begin
         bad_count++;
         complete_run();
      end
   endtask

   initial begin
      {core_clk, rst_b, wb_cyc, wb_stb, wb_we, mr, seen} = '0;
      {sel_a, sel_b, mon_n, run_a, run_b} = '1;
      {wb_sel, wb_adr, wb_dat} = 44'h1;
      bad_count = 0;
      samples_checked = 0;
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 8'(i * 4), 8'h00);
         chk(rd, (i == 5) ? 32'h60 : 32'h0);
      end
      foreach (rows[i]) begin
         wb(1'b1, rows[i][23:16], rows[i][15:8]);
         wb(1'b0, rows[i][23:16], 8'h00);
         chk(rd, {24'h0, rows[i][7:0]});
      end
      // Ratio two gives two high cycles; output B still follows divider A.
      wb(1'b1, 8'h0C, 8'h01);
      await(1, 1200);
      chk({31'h0, out_b}, 32'h1);
      n = 0;
      while (out_a === 1'b1 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      chk(n, 2);
      wb(1'b1, 8'h14, 8'hE0);
      repeat (3) @(posedge core_clk);
      repeat (40) begin
         @(posedge core_clk);
         seen = seen | out_a | out_b;
      end
      chk({31'h0, seen}, 32'h0);
      wb(1'b1, 8'h14, 8'h20);
      repeat (3) @(posedge core_clk);
      chk({29'h0, oe_a, oe_b, out_a}, 32'h2);
      // Failover without revert, then the flags stick until a device reset.
      wb(1'b1, 8'h14, 8'h60);
      mon_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      run_a <= 1'b0;
      await(0, 60);
      wb(1'b0, 8'h1C, 8'h00);
      chk(rd, 32'h50);
      run_a <= 1'b1;
      repeat (20) @(posedge core_clk);
      wb(1'b0, 8'h1C, 8'h00);
      chk(rd, 32'h50);
      wb(1'b1, 8'h18, 8'h10);
      wb(1'b0, 8'h1C, 8'h00);
      chk({rd[30:0], fail}, 32'h0);
      // Revert clears flags and reselects the default input.
      wb(1'b1, 8'h14, 8'h62);
      run_a <= 1'b0;
      await(0, 60);
      run_a <= 1'b1;
      repeat (20) @(posedge core_clk);
      wb(1'b0, 8'h1C, 8'h00);
      chk(rd, 32'h0);
      // Enabling input A alone by register idles the monitor.
      wb(1'b1, 8'h14, 8'h64);
      run_b <= 1'b0;
      repeat (30) @(posedge core_clk);
      chk({31'h0, fail}, 32'h0);
      // A rising monitor-enable pin clears a stuck fault.
      wb(1'b1, 8'h14, 8'h60);
      await(0, 60);
      // Source B runs again first, so no late detection can outlast the clear.
      run_b <= 1'b1;
      repeat (8) @(posedge core_clk);
      mon_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      mon_n <= 1'b0;
      wb(1'b0, 8'h1C, 8'h00);
      chk({rd[30:0], fail}, 32'h0);
      // Swap picks input B; output B follows divider B; the pin reset undoes both.
      wb(1'b1, 8'h18, 8'h0C);
      wb(1'b0, 8'h1C, 8'h00);
      chk(rd, 32'h10);
      repeat (20) @(posedge core_clk);
      mr <= 1'b1;
      repeat (8) @(posedge core_clk);
      mr <= 1'b0;
      repeat (8) @(posedge core_clk);
      wb(1'b0, 8'h18, 8'h00);
      chk({rd[30:0], fail}, 32'h0);
      wb(1'b0, 8'h1C, 8'h00);
      chk(rd, 32'h0);
      complete_run();
   end
endmodule
